/* design/pabo_pkg.sv */
// shared types and constants for the port a/b alternate function override block
package pabo_pkg;
   // lines per port
   localparam int unsigned PORT_WIDTH = 8;
   // port b line positions
   localparam int unsigned PB_LINE_SCK   = 1;
   localparam int unsigned PB_LINE_MOSI  = 2;
   localparam int unsigned PB_LINE_MISO  = 3;
   localparam int unsigned PB_LINE_TMR0  = 4;
   localparam int unsigned PB_LINE_TMR1A = 5;
   localparam int unsigned PB_LINE_TMR1B = 6;
   localparam int unsigned PB_LINE_TMR2  = 7;
   // synchroniser depth and reset value of sampled pins
   localparam int unsigned SYNC_STAGES   = 2;
   localparam logic [7:0]  SYNC_RST_VAL  = 8'h00;

   // per-port override signals from the alternate functions
   typedef struct packed {
      logic [7:0] pullup_override_en;
      logic [7:0] pullup_override_val;
      logic [7:0] dir_override_en;
      logic [7:0] dir_override_val;
      logic [7:0] value_override_en;
      logic [7:0] value_override_val;
      logic [7:0] input_enable_override_en;
      logic [7:0] input_enable_override_val;
   } pabo_ovr_s;

   // per-port software register bits
   typedef struct packed {
      logic [7:0] line_direction_bit;
      logic [7:0] line_out_latch_bit;
   } pabo_sw_s;

   // per-port resolved pad controls
   typedef struct packed {
      logic [7:0] pullup_en;
      logic [7:0] drive_en_n;
      logic [7:0] drive_val;
   } pabo_pad_s;

   // memory interface request towards port a
   typedef struct packed {
      logic       ext_mem_enable;
      logic       write_phase;
      logic       address_active_phase;
      logic [7:0] addr_low;
      logic [7:0] data_out;
   } pabo_mem_s;

   // timer and spi requests towards port b
   typedef struct packed {
      logic timer2_compare_out;
      logic timer2_compare_en;
      logic timer1_compare_out_c;
      logic timer1_compare_en_c;
      logic timer1_compare_out_b;
      logic timer1_compare_en_b;
      logic timer1_compare_out_a;
      logic timer1_compare_en_a;
      logic timer0_compare_out;
      logic timer0_compare_en;
      logic spi_enable;
      logic spi_master;
      logic spi_slave_out;
      logic spi_master_out;
      logic spi_sck_out;
   } pabo_perb_s;
endpackage

/* design/pabo_pad_resolve.sv */
// resolves override signals and register bits into pad controls for one port
`timescale 1ns/1ps
module pabo_pad_resolve (
   // overrides and register bits
   input  wire pabo_pkg::pabo_ovr_s ovr_in,
   input  wire pabo_pkg::pabo_sw_s  sw_in,
   input  wire logic                global_pullup_disable_in,
   // resolved pad controls
   output pabo_pkg::pabo_pad_s      pad_out
);
   logic [7:0] drive_on;

   // driver enable: override value or direction bit
   assign drive_on = (ovr_in.dir_override_en & ovr_in.dir_override_val) |
                     (~ovr_in.dir_override_en & sw_in.line_direction_bit);

   // active-low enable, low while the line drives
   assign pad_out.drive_en_n = ~drive_on;

   // value comes from override when enabled, else from the latch bit
   assign pad_out.drive_val = (ovr_in.value_override_en & ovr_in.value_override_val) |
                     (~ovr_in.value_override_en & sw_in.line_out_latch_bit);

   // pull-up: override, else input with latch set and pull-ups allowed
   assign pad_out.pullup_en = (ovr_in.pullup_override_en & ovr_in.pullup_override_val) |
                     (~ovr_in.pullup_override_en & ~drive_on & sw_in.line_out_latch_bit &
                      {8{~global_pullup_disable_in}});
endmodule // pabo_pad_resolve

/* design/pabo_top.sv */
// port a/b alternate function override generation and pad resolution
`timescale 1ns/1ps
module pabo_top #(
   parameter int unsigned WIDTH = pabo_pkg::PORT_WIDTH
) (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // mode and global controls
   input  wire logic                 legacy_mode_in,
   input  wire logic                 global_pullup_disable_in,
   // memory interface request
   input  wire pabo_pkg::pabo_mem_s  mem_in,
   // timer and spi requests
   input  wire pabo_pkg::pabo_perb_s perb_in,
   // port software register bits
   input  wire pabo_pkg::pabo_sw_s   sw_a_in,
   input  wire pabo_pkg::pabo_sw_s   sw_b_in,
   // raw pad inputs
   input  wire logic [WIDTH-1:0]     pin_sampled_input_a_in,
   input  wire logic [WIDTH-1:0]     pin_sampled_input_b_in,
   // override signals as seen by the pad logic
   output pabo_pkg::pabo_ovr_s       ovr_a_out,
   output pabo_pkg::pabo_ovr_s       ovr_b_out,
   // resolved pad controls
   output pabo_pkg::pabo_pad_s       pad_a_out,
   output pabo_pkg::pabo_pad_s       pad_b_out,
   // synchronised inputs to the alternate functions
   output logic [WIDTH-1:0]          mem_data_in_out,
   output logic                      spi_master_in_out,
   output logic                      spi_slave_in_out,
   output logic                      spi_sck_in_out
);
   // all state: two-stage synchronisers for both ports
   typedef struct packed {
      logic [WIDTH-1:0] a_meta;
      logic [WIDTH-1:0] a_sync;
      logic [WIDTH-1:0] b_meta;
      logic [WIDTH-1:0] b_sync;
   } pabo_state_s;

   // registered state and its next value
   pabo_state_s st_r;
   pabo_state_s st_nxt;

   // override bundles per port and the shared qualifiers
   pabo_pkg::pabo_ovr_s oa;
   pabo_pkg::pabo_ovr_s ob;
   logic                bus_out_phase;
   logic                spi_mst;
   logic                spi_slv;
   logic                oc7_en;
   logic                oc7_val;

   // replicate a bit across a port
   function automatic logic [7:0] fan8(input logic b);
      fan8 = {8{b}};
   endfunction

   // pull-up value for a line an alternate function holds as input
   function automatic logic keep_pullup(input logic latch_bit, input logic pu_off);
      keep_pullup = latch_bit & ~pu_off; // latch set and pull-ups allowed
   endfunction

   // synchroniser next state: first stage read only by the second
   // the pads change with no regard to clk_in, so the first stage may go
   // metastable; only the second stage feeds the alternate functions
   // this costs two edges of latency on every sampled pin, a price the
   // peripherals already allow for in their own timing
   always_comb begin
      st_nxt        = st_r;
      st_nxt.a_meta = pin_sampled_input_a_in;
      st_nxt.a_sync = st_r.a_meta;
      st_nxt.b_meta = pin_sampled_input_b_in;
      st_nxt.b_sync = st_r.b_meta;
   end

   // state register
   // reset loads constants only; no pin value reaches the flops in reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '{default: pabo_pkg::SYNC_RST_VAL[WIDTH-1:0]};
      end else begin
         st_r <= st_nxt;
      end
   end

   // bus drives while writing or while the address is out
   assign bus_out_phase = mem_in.write_phase | mem_in.address_active_phase;

   // port a overrides, one bit per bus line
   // the memory interface takes all eight lines at once: an address or a
   // write phase turns the drivers on, any other time the lines listen for
   // read data; the pull-ups may only return while the bus is quiet, so
   // they never fight a driven address or data byte
   always_comb begin
      // ownership: the pull-up, direction and value enables follow the memory enable
      oa.pullup_override_en        = fan8(mem_in.ext_mem_enable);
      oa.dir_override_en           = fan8(mem_in.ext_mem_enable);
      oa.value_override_en         = fan8(mem_in.ext_mem_enable);
      // direction and value follow the bus phase
      oa.dir_override_val          = fan8(bus_out_phase);
      oa.value_override_val        = (mem_in.addr_low & fan8(mem_in.address_active_phase)) |
                                     (mem_in.data_out & fan8(mem_in.write_phase));
      // pull-up only while the bus is quiet
      oa.pullup_override_val       = fan8(~bus_out_phase) & sw_a_in.line_out_latch_bit &
                                     fan8(~global_pullup_disable_in);
      // input enable is never overridden on this port
      oa.input_enable_override_en  = 8'h00;
      oa.input_enable_override_val = 8'h00;
   end

   // spi role qualifiers
   // the role picks the lines forced to input; the other spi lines keep
   // their direction bit, so software still sets it for an output to leave
   assign spi_mst = perb_in.spi_enable & perb_in.spi_master;
   assign spi_slv = perb_in.spi_enable & ~perb_in.spi_master;

   // pb7 source: timer2 first, timer1 c only outside legacy mode
   // when both timers claim the line timer2 wins; no modulator mixes them
   // here, so a user who enables both sees only timer2 on the pin
   assign oc7_en  = perb_in.timer2_compare_en |
                    (perb_in.timer1_compare_en_c & ~legacy_mode_in);
   assign oc7_val = perb_in.timer2_compare_en ? perb_in.timer2_compare_out
                                              : perb_in.timer1_compare_out_c;

   // port b overrides; direction for compare lines stays with software
   // line 0 (slave select) keeps its register bits: every override of it
   // stays at zero from the default below
   always_comb begin
      ob = '0;
      // compare outputs only set the value, direction bit gates the pin
      // a compare line with its direction bit clear stays an input
      ob.value_override_en[pabo_pkg::PB_LINE_TMR2]   = oc7_en;
      ob.value_override_val[pabo_pkg::PB_LINE_TMR2]  = oc7_val;
      ob.value_override_en[pabo_pkg::PB_LINE_TMR1B]  = perb_in.timer1_compare_en_b;
      ob.value_override_val[pabo_pkg::PB_LINE_TMR1B] = perb_in.timer1_compare_out_b;
      ob.value_override_en[pabo_pkg::PB_LINE_TMR1A]  = perb_in.timer1_compare_en_a;
      ob.value_override_val[pabo_pkg::PB_LINE_TMR1A] = perb_in.timer1_compare_out_a;
      ob.value_override_en[pabo_pkg::PB_LINE_TMR0]   = perb_in.timer0_compare_en;
      ob.value_override_val[pabo_pkg::PB_LINE_TMR0]  = perb_in.timer0_compare_out;
      // miso: forced input as master, slave output value as slave
      // a forced input still takes its pull-up from the latch bit
      ob.dir_override_en[pabo_pkg::PB_LINE_MISO]     = spi_mst;
      ob.pullup_override_en[pabo_pkg::PB_LINE_MISO]  = spi_mst;
      ob.pullup_override_val[pabo_pkg::PB_LINE_MISO] =
         keep_pullup(sw_b_in.line_out_latch_bit[pabo_pkg::PB_LINE_MISO],
                     global_pullup_disable_in);
      ob.value_override_en[pabo_pkg::PB_LINE_MISO]   = spi_slv;
      ob.value_override_val[pabo_pkg::PB_LINE_MISO]  = perb_in.spi_slave_out;
      // mosi: forced input as slave, master output value as master
      // a forced input still takes its pull-up from the latch bit
      ob.dir_override_en[pabo_pkg::PB_LINE_MOSI]     = spi_slv;
      ob.pullup_override_en[pabo_pkg::PB_LINE_MOSI]  = spi_slv;
      ob.pullup_override_val[pabo_pkg::PB_LINE_MOSI] =
         keep_pullup(sw_b_in.line_out_latch_bit[pabo_pkg::PB_LINE_MOSI],
                     global_pullup_disable_in);
      ob.value_override_en[pabo_pkg::PB_LINE_MOSI]   = spi_mst;
      ob.value_override_val[pabo_pkg::PB_LINE_MOSI]  = perb_in.spi_master_out;
      // sck: forced input as slave, clock output value as master
      // a forced input still takes its pull-up from the latch bit
      ob.dir_override_en[pabo_pkg::PB_LINE_SCK]      = spi_slv;
      ob.pullup_override_en[pabo_pkg::PB_LINE_SCK]   = spi_slv;
      ob.pullup_override_val[pabo_pkg::PB_LINE_SCK]  =
         keep_pullup(sw_b_in.line_out_latch_bit[pabo_pkg::PB_LINE_SCK],
                     global_pullup_disable_in);
      ob.value_override_en[pabo_pkg::PB_LINE_SCK]    = spi_mst;
      ob.value_override_val[pabo_pkg::PB_LINE_SCK]   = perb_in.spi_sck_out;
   end

   // overrides leave with no register so pads follow in the same cycle
   // a register here would let a pad lag its peripheral by one clock and
   // put a stale address on the bus at the start of every access
   assign ovr_a_out = oa;
   assign ovr_b_out = ob;

   // pad resolution for port a
   // both ports share one resolver, so the pad rules are coded once
   pabo_pad_resolve u_res_a (
      .ovr_in                   (oa),
      .sw_in                    (sw_a_in),
      .global_pullup_disable_in (global_pullup_disable_in),
      .pad_out                  (pad_a_out)
   );

   // pad resolution for port b
   // port b sees spi and timer overrides, port a only the memory bus
   pabo_pad_resolve u_res_b (
      .ovr_in                   (ob),
      .sw_in                    (sw_b_in),
      .global_pullup_disable_in (global_pullup_disable_in),
      .pad_out                  (pad_b_out)
   );

   // synchronised pin inputs to the alternate functions
   // read data and the spi inputs come from the second stage only; they
   // read zero in reset and for the first edge after it
   // a pin change shows here on the second edge after it
   assign mem_data_in_out   = st_r.a_sync;
   assign spi_master_in_out = st_r.b_sync[pabo_pkg::PB_LINE_MISO];
   assign spi_slave_in_out  = st_r.b_sync[pabo_pkg::PB_LINE_MOSI];
   assign spi_sck_in_out    = st_r.b_sync[pabo_pkg::PB_LINE_SCK];
endmodule // pabo_top

/* testbench/pabo_chk_sva.sv */
// concurrent checks on the override and pad outputs of the port a/b block
`timescale 1ns/1ps
module pabo_chk_sva #(
   parameter int unsigned WIDTH = 8
) (
   // clock, reset and controls
   input wire logic                 clk_in,
   input wire logic                 rst_n_in,
   input wire logic                 legacy_mode_in,
   input wire logic                 global_pullup_disable_in,
   input wire pabo_pkg::pabo_mem_s  mem_in,
   input wire pabo_pkg::pabo_perb_s perb_in,
   input wire pabo_pkg::pabo_sw_s   sw_a_in,
   input wire pabo_pkg::pabo_sw_s   sw_b_in,
   input wire logic [WIDTH-1:0]     pin_sampled_input_a_in,
   input wire logic [WIDTH-1:0]     pin_sampled_input_b_in,
   // watched outputs
   input wire pabo_pkg::pabo_ovr_s  ovr_a_out,
   input wire pabo_pkg::pabo_ovr_s  ovr_b_out,
   input wire pabo_pkg::pabo_pad_s  pad_a_out,
   input wire pabo_pkg::pabo_pad_s  pad_b_out,
   input wire logic [WIDTH-1:0]     mem_data_in_out,
   input wire logic                 spi_master_in_out,
   input wire logic                 spi_slave_in_out,
   input wire logic                 spi_sck_in_out
);
   logic       bus_on;
   logic [7:0] pu_ok;
   // memory phase in use and pull-up permission per line
   assign bus_on = mem_in.write_phase | mem_in.address_active_phase;
   assign pu_ok  = {8{~global_pullup_disable_in}};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   mem_own_a: assert property (
      mem_in.ext_mem_enable |-> (&{ovr_a_out.pullup_override_en, ovr_a_out.dir_override_en,
      ovr_a_out.value_override_en}) && ovr_a_out.input_enable_override_en == 8'h00)
      else $error("port a not handed to memory bus");
   mem_dir_a: assert property (
      mem_in.ext_mem_enable |-> pad_a_out.drive_en_n == {8{~bus_on}})
      else $error("port a direction wrong");
   mem_val_a: assert property (
      mem_in.ext_mem_enable && bus_on |-> pad_a_out.drive_val == (mem_in.addr_low
      & {8{mem_in.address_active_phase}} | mem_in.data_out & {8{mem_in.write_phase}}))
      else $error("port a bus value wrong");
   mem_pull_a: assert property (
      mem_in.ext_mem_enable |-> pad_a_out.pullup_en == ({8{~bus_on}} & sw_a_in.line_out_latch_bit & pu_ok))
      else $error("port a pull-up wrong");
   pb7_src_a: assert property (
      ovr_b_out.value_override_en[7] == (perb_in.timer2_compare_en
      | perb_in.timer1_compare_en_c & ~legacy_mode_in)) else $error("line b7 source wrong");
   spi_dir_a: assert property (
      perb_in.spi_enable |-> pad_b_out.drive_en_n[3:1] == (perb_in.spi_master ?
      {1'h1, ~sw_b_in.line_direction_bit[2:1]} : {~sw_b_in.line_direction_bit[3], 2'h3}))
      else $error("spi line direction wrong");
   pb_dir_a: assert property (
      pad_b_out.drive_en_n == ~(ovr_b_out.dir_override_en & ovr_b_out.dir_override_val
      | ~ovr_b_out.dir_override_en & sw_b_in.line_direction_bit)) else $error("port b driver wrong");
   pb_val_a: assert property (
      (~pad_b_out.drive_en_n & (pad_b_out.drive_val ^ (ovr_b_out.value_override_en
      & ovr_b_out.value_override_val | ~ovr_b_out.value_override_en
      & sw_b_in.line_out_latch_bit))) == 8'h00) else $error("port b value wrong");
   in_sync_a: assert property (
      rst_n_in && $past(rst_n_in) && $past(rst_n_in, 2) |-> mem_data_in_out
      == $past(pin_sampled_input_a_in, 2) && {spi_master_in_out, spi_slave_in_out,
      spi_sck_in_out} == $past(pin_sampled_input_b_in[3:1], 2)) else $error("input sync wrong");
   // main scenarios reached
   cover property (mem_in.ext_mem_enable && mem_in.write_phase);
   cover property (perb_in.spi_enable && perb_in.spi_master);
   cover property (legacy_mode_in && perb_in.timer1_compare_en_c);
endmodule // pabo_chk_sva

/* testbench/pabo_mem_model.sv */
// memory interface model walking port a through address, write and idle phases
`timescale 1ns/1ps
module pabo_mem_model (
   // clock and reset
   input  wire logic           clk_in,
   input  wire logic           rst_n_in,
   // request from the bench
   input  wire logic           en_in,
   input  wire logic           go_in,
   input  wire logic [7:0]     addr_in,
   input  wire logic [7:0]     data_in,
   // bus request towards the block
   output pabo_pkg::pabo_mem_s mem_out
);
   logic [1:0] ph_r;
   // one address cycle, then one write cycle, then idle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) ph_r <= 2'h0;
      else ph_r <= go_in ? 2'h1 : {ph_r == 2'h1, 1'h0};
   end
   // address flagged only while driven; outside its phase each field is scrambled
   assign mem_out = '{ext_mem_enable: en_in, write_phase: ph_r[1],
      address_active_phase: ph_r[0], addr_low: ph_r[0] ? addr_in : ~addr_in,
      data_out: ph_r[1] ? data_in : ~data_in};
endmodule // pabo_mem_model

/* testbench/tb_top.sv */
// self-checking bench for the port a/b override block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   // stimulus and observed signals
   logic                 clk_in = 1'h0, rst_n_in = 1'h0, legacy_mode_in = 1'h0, men = 1'h0;
   logic                 global_pullup_disable_in = 1'h0, go = 1'h0;
   logic [7:0]           pin_sampled_input_a_in = 8'h00, pin_sampled_input_b_in = 8'h00;
   logic [7:0]           mem_data_in_out;
   logic                 spi_master_in_out, spi_slave_in_out, spi_sck_in_out;
   pabo_pkg::pabo_mem_s  mem_in;
   pabo_pkg::pabo_perb_s perb_in = '0;
   pabo_pkg::pabo_sw_s   sw_a_in = '0, sw_b_in = '0;
   pabo_pkg::pabo_ovr_s  ovr_a_out, ovr_b_out;
   pabo_pkg::pabo_pad_s  pad_a_out, pad_b_out;
   int                   err_total = 0, checked = 0;
   // 100 ns clock
   always #50 clk_in = ~clk_in;
   // design and memory interface model
   pabo_top dut (.clk_in, .rst_n_in, .legacy_mode_in, .global_pullup_disable_in, .mem_in,
      .perb_in, .sw_a_in, .sw_b_in, .pin_sampled_input_a_in, .pin_sampled_input_b_in,
      .ovr_a_out, .ovr_b_out, .pad_a_out, .pad_b_out, .mem_data_in_out, .spi_master_in_out,
      .spi_slave_in_out, .spi_sck_in_out);
   pabo_mem_model u_mem (.clk_in, .rst_n_in, .en_in(men), .go_in(go), .addr_in(8'hA5),
      .data_in(8'h3C), .mem_out(mem_in));
   // drive port b controls on a rising edge, return where outputs settled
   task automatic drive(input pabo_pkg::pabo_perb_s p, input pabo_pkg::pabo_sw_s s,
                        input logic leg, input logic pu_off);
      @(posedge clk_in);
      perb_in <= p;
      sw_b_in <= s;
      legacy_mode_in <= leg;
      global_pullup_disable_in <= pu_off;
      @(negedge clk_in);
   endtask
   // counts and verdict, then stop
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog far beyond the 33 or so cycles the tests take
   initial begin
      #100000;
      err_total++;
      print_verdict;
   end
   initial begin : main
      int i;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      // memory cycle: address, write, idle
      @(posedge clk_in);
      men <= 1'h1;
      sw_a_in <= '{8'h00, 8'hF0};
      go <= 1'h1;
      @(posedge clk_in);
      go <= 1'h0;
      @(negedge clk_in);
      `CHK(pad_a_out, {8'h00, 8'h00, 8'hA5});
      @(negedge clk_in);
      `CHK(pad_a_out, {8'h00, 8'h00, 8'h3C});
      @(negedge clk_in);
      `CHK(pad_a_out[23:8], 16'hF0FF);
      drive(perb_in, sw_b_in, 1'h0, 1'h1);
      `CHK(pad_a_out.pullup_en, 8'h00);
      @(posedge clk_in);
      men <= 1'h0;
      sw_a_in <= '{8'h0F, 8'h33};
      global_pullup_disable_in <= 1'h0;
      @(negedge clk_in);
      `CHK(ovr_a_out.value_override_en, 8'h00);
      `CHK(pad_a_out[23:8], 16'h30F0);
      `CHK(pad_a_out.drive_val[3:0], 4'h3);
      $display("memory test done");
      // compare outputs on b7..b4, every source and mode combination
      for (i = 0; i < 16; i++) begin
         drive({i[0], i[1], ~i[0], i[2], i[0], i[1], ~i[0], i[1], i[0], i[1], 5'h00},
               '{8'hFF, 8'h00}, i[3], 1'h0);
         `CHK(ovr_b_out.value_override_en[7], i[1] | i[2] & ~i[3]);
         `CHK(pad_b_out.drive_val[7:4], {(i[1] | i[2] & ~i[3]) & (i[1] ? i[0] : ~i[0]),
              {3{i[1]}} & {i[0], ~i[0], i[0]}});
      end
      drive(perb_in, '{8'h00, 8'h00}, 1'h0, 1'h0);
      `CHK(pad_b_out.drive_en_n[7:4], 4'hF);
      $display("timer test done");
      // spi slave then master on b3..b1
      for (i = 0; i < 2; i++) begin
         drive({10'h000, 1'h1, i[0], 3'h0}, '{8'h0E, 8'h0E}, 1'h0, 1'h0);
         `CHK(pad_b_out.drive_en_n[3:1], i[0] ? 3'h4 : 3'h3);
         `CHK(pad_b_out.pullup_en[3:1], i[0] ? 3'h4 : 3'h3);
         `CHK(pad_b_out.drive_val[3:1] & ~pad_b_out.drive_en_n[3:1], 3'h0);
      end
      drive(perb_in, sw_b_in, 1'h0, 1'h1);
      `CHK(pad_b_out.pullup_en[3:1], 3'h0);
      $display("spi test done");
      // input synchronisers: two edges of latency
      @(posedge clk_in);
      pin_sampled_input_a_in <= 8'h5A;
      pin_sampled_input_b_in <= 8'h0A;
      @(negedge clk_in);
      `CHK(mem_data_in_out, 8'h00);
      @(negedge clk_in);
      `CHK(mem_data_in_out, 8'h00);
      `CHK({spi_master_in_out, spi_slave_in_out, spi_sck_in_out}, 3'h0);
      @(negedge clk_in);
      `CHK(mem_data_in_out, 8'h5A);
      `CHK({spi_master_in_out, spi_slave_in_out, spi_sck_in_out}, 3'h5);
      $display("sync test done");
      print_verdict;
   end
endmodule // tb_top
bind pabo_top pabo_chk_sva #(.WIDTH(WIDTH)) u_chk (.clk_in, .rst_n_in, .legacy_mode_in,
   .global_pullup_disable_in, .mem_in, .perb_in, .sw_a_in, .sw_b_in, .pin_sampled_input_a_in,
   .pin_sampled_input_b_in, .ovr_a_out, .ovr_b_out, .pad_a_out, .pad_b_out, .mem_data_in_out,
   .spi_master_in_out, .spi_slave_in_out, .spi_sck_in_out);
